// >>> hdl/ppmc_params.svh
// Register offsets, field positions, reset values and encodings of the parallel port mode logic.
`ifndef PPMC_PARAMS_SVH
`define PPMC_PARAMS_SVH
// Port-side register offsets, relative to the parallel port base.
`define PPMC_OFS_DATA       11'h000
`define PPMC_OFS_STATUS     11'h001
`define PPMC_OFS_CTRL       11'h002
`define PPMC_OFS_EMC        11'h402
`define PPMC_OFS_SL_INDEX   11'h403
`define PPMC_OFS_SL_DATA    11'h404
// Configuration-side indexes.
`define PPMC_CFG_PORT_MODE  8'hF0
`define PPMC_CFG_ROUTE      8'hF1
`define PPMC_CFG_FUNC_EN    8'h00
// Second-level register indexes.
`define PPMC_SL_SECOND_CTRL 3'h2
`define PPMC_SL_ROUTE       3'h4
// Field positions.
`define PPMC_FEN_PP_BIT     4
`define PPMC_CFG_DYN_BIT    4
`define PPMC_SC_COMPAT_BIT  7
`define PPMC_SC_EPP19_BIT   4
`define PPMC_CTRL_DIR_BIT   5
// Reset values: dynamic configuration enabled, ECP sub-mode selected.
`define PPMC_RST_PORT_MODE  8'hF0
`define PPMC_RST_EMC        8'h60
`define PPMC_RST_FUNC_EN    8'h00
`define PPMC_RST_ROUTE      8'h07
`define PPMC_RST_SECOND     8'h00
// Static mode codes held in bits 7-5 of the port mode configuration.
`define PPMC_ST_SPP_COMPAT  3'h0
`define PPMC_ST_SPP_EXT     3'h1
`define PPMC_ST_EPP17       3'h2
`define PPMC_ST_EPP19       3'h3
`define PPMC_ST_DYN_A       3'h6
`define PPMC_ST_DYN_B       3'h7
// Sub-mode codes held in bits 7-5 of the extended mode control.
`define PPMC_EM_SPP_COMPAT  3'h0
`define PPMC_EM_SPP_EXT     3'h1
`define PPMC_EM_FIFO_OUT    3'h2
`define PPMC_EM_ECP         3'h3
`define PPMC_EM_EPP         3'h4
// Interrupt lines that may not be selected.
`define PPMC_IRQ_BAD_A      4'h2
`define PPMC_IRQ_BAD_B      4'hD
`define PPMC_DMA_CHANNELS   3
`endif

// >>> hdl/ppmc_pkg.sv
// Types shared by the parallel port mode logic.
package ppmc_pkg;
  typedef enum logic [2:0] {
    PPMC_MODE_SPP_COMPAT = 3'h0,
    PPMC_MODE_SPP_EXT    = 3'h1,
    PPMC_MODE_EPP17      = 3'h2,
    PPMC_MODE_EPP19      = 3'h3,
    PPMC_MODE_FIFO_OUT   = 3'h4,
    PPMC_MODE_ECP        = 3'h5
  } ppmc_mode_t;

  typedef enum logic [1:0] {
    PPMC_HS_IDLE   = 2'h0,
    PPMC_HS_SETUP  = 2'h1,
    PPMC_HS_STROBE = 2'h2,
    PPMC_HS_HOLD   = 2'h3
  } ppmc_hs_t;
endpackage

// >>> hdl/ppmc_fifo.sv
// Sixteen-entry data FIFO used for ECP and FIFO output transfers.
`timescale 1ns/10ps
module ppmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int THR   = 8
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  // Fill side.
  input  wire logic             wr_valid_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  wr_ready_o,
  // Drain side.
  output logic                  rd_valid_o,
  output logic [WIDTH-1:0]      rd_data_o,
  input  wire logic             rd_ready_i,
  // Level flags.
  output logic                  empty_o,
  output logic                  full_o,
  output logic                  thr_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Handshakes on both sides; full and empty come from the count.
  assign push       = wr_valid_i && !full_o;
  assign pop        = rd_ready_i && !empty_o;
  assign full_o     = (cnt_r == (AW+1)'(DEPTH));
  assign empty_o    = (cnt_r == '0);
  assign wr_ready_o = !full_o;
  assign rd_valid_o = !empty_o;
  assign rd_data_o  = mem_r[rp_r];
  assign thr_o      = (cnt_r >= (AW+1)'(THR));

  // Storage array; no reset needed on data.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= wr_data_i;
    end
  end

  // Pointers and count; flush drops all entries at a mode change.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flush_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> hdl/ppmc_strobe.sv
// Hardware handshake sequencer that strobes one byte out to the peripheral.
`timescale 1ns/10ps
module ppmc_strobe #(
  parameter int PHASE = 4
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Byte source.
  input  wire logic       valid_i,
  output logic            take_o,
  // Peripheral handshake.
  input  wire logic       busy_i,
  output logic            strobe_n_o,
  output logic            active_o
);
  logic [7:0]       tmr_r;
  ppmc_pkg::ppmc_hs_t st_r;

  assign take_o   = (st_r == ppmc_pkg::PPMC_HS_IDLE) && valid_i && !busy_i;
  assign active_o = (st_r != ppmc_pkg::PPMC_HS_IDLE);

  // Setup, strobe and hold each last PHASE cycles; busy gates the start.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r       <= ppmc_pkg::PPMC_HS_IDLE;
      tmr_r      <= 8'h00;
      strobe_n_o <= 1'b1;
    end else begin
      unique case (st_r)
        ppmc_pkg::PPMC_HS_IDLE: begin
          if (take_o) begin
            st_r  <= ppmc_pkg::PPMC_HS_SETUP;
            tmr_r <= 8'(PHASE - 1);
          end
        end
        ppmc_pkg::PPMC_HS_SETUP: begin
          if (tmr_r == 8'h00) begin
            st_r       <= ppmc_pkg::PPMC_HS_STROBE;
            strobe_n_o <= 1'b0;
            tmr_r      <= 8'(PHASE - 1);
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        ppmc_pkg::PPMC_HS_STROBE: begin
          if (tmr_r == 8'h00) begin
            st_r       <= ppmc_pkg::PPMC_HS_HOLD;
            strobe_n_o <= 1'b1;
            tmr_r      <= 8'(PHASE - 1);
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        ppmc_pkg::PPMC_HS_HOLD: begin
          if (tmr_r == 8'h00) begin
            st_r <= ppmc_pkg::PPMC_HS_IDLE;
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
      endcase
    end
  end
endmodule

// >>> hdl/ppmc_top.sv
// Mode selection, routing, activation and data path of the parallel port.
`timescale 1ns/10ps
`include "ppmc_params.svh"

// Behaviour
// - After reset the port runs in ECP mode until software picks another.
// - ECP sub-mode comes from bits 7-5 of the extended mode control at 402h.
// - Static mode comes from bits 7-5 of the configuration register at index F0h.
// - Dynamic change only when config bit 4 is 1 and bits 7-5 are 110 or 111.
// - Dynamic mode follows extended mode field plus second control bit 4.
// - Second-level registers reached via index at base+403h and data at base+404h.
// - Port interrupt routable to ISA lines 1 to 15 except 2 and 13.
// - Port DMA request and acknowledge routable to one of three 8-bit channels.
// - Port stays inactive until function enable bit 4 is set.
// - ECP mode has a 16-entry FIFO with threshold interrupt for PIO and DMA.
// - SPP compatible mode drives data out only, paced by software handshake.
// - FIFO output mode adds an output FIFO sequenced by a hardware handshake.
// - SPP extended mode moves full bytes in either direction.
// - EPP 1.9 uses the full handshake; EPP 1.7 runs without it.
// - Static codes: 000 compatible, 001 extended, 010 EPP 1.7, 011 EPP 1.9.
module ppmc_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_THR   = 8,
  parameter int HS_PHASE   = 4
) (
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // Configuration access (index space of the logical device).
  input  wire logic        CFG_WR_I,
  input  wire logic        CFG_RD_I,
  input  wire logic [7:0]  CFG_IDX_I,
  input  wire logic [7:0]  CFG_WDATA_I,
  output logic      [7:0]  CFG_RDATA_O,
  // Port register access, offset from the port base.
  input  wire logic        PORT_WR_I,
  input  wire logic        PORT_RD_I,
  input  wire logic [10:0] PORT_OFS_I,
  input  wire logic [7:0]  PORT_WDATA_I,
  output logic      [7:0]  PORT_RDATA_O,
  // ISA routing.
  output logic      [15:0] ISA_IRQ_O,
  output logic      [2:0]  ISA_DRQ_O,
  input  wire logic [2:0]  ISA_DACK_N_I,
  // Peripheral side.
  input  wire logic [7:0]  PD_I,
  output logic      [7:0]  PD_O,
  output logic             PD_OE_O,
  output logic             STROBE_N_O,
  input  wire logic        BUSY_I,
  input  wire logic        ACK_N_I,
  // Observed state.
  output logic      [2:0]  MODE_O,
  output logic             ACTIVE_O
);
  // Configuration and port registers.
  logic [7:0] port_mode_configuration_r;
  logic [7:0] function_enable_first_r;
  logic [7:0] route_cfg_r;
  logic [7:0] extended_mode_control_r;
  logic [7:0] second_level_index_r;
  logic [7:0] second_control_r;
  logic [7:0] dma_route_r;
  logic [7:0] data_latch_r;
  logic [7:0] ctrl_r;
  ppmc_pkg::ppmc_mode_t mode_nxt;
  logic       dyn_en;
  logic       active;
  logic       pd_drive;
  logic [2:0] mode_q_r;
  // FIFO and sequencer links.
  logic       fifo_wr;
  logic       fifo_wr_ready;
  logic       fifo_rd_valid;
  logic [7:0] fifo_rd_data;
  logic       fifo_pop;
  logic       fifo_empty;
  logic       fifo_full;
  logic       fifo_thr;
  logic       hs_take;
  logic       hs_strobe_n;
  logic       hs_active;
  logic       fifo_mode;
  logic       ecp_mode;
  logic       mode_chg;
  logic [1:0] dma_sel;
  logic       dma_ack;

  // Dynamic configuration needs bit 4 set and code 110 or 111 in bits 7-5.
  assign dyn_en = port_mode_configuration_r[`PPMC_CFG_DYN_BIT] &&
                  (port_mode_configuration_r[7:5] == `PPMC_ST_DYN_A ||
                   port_mode_configuration_r[7:5] == `PPMC_ST_DYN_B);
  assign active = function_enable_first_r[`PPMC_FEN_PP_BIT];

  // Mode decode; static codes take effect, dynamic codes consult the extended control.
  always_comb begin
    mode_nxt = ppmc_pkg::PPMC_MODE_ECP;
    if (!dyn_en) begin
      unique case (port_mode_configuration_r[7:5])
        `PPMC_ST_SPP_COMPAT: mode_nxt = ppmc_pkg::PPMC_MODE_SPP_COMPAT;
        `PPMC_ST_SPP_EXT:    mode_nxt = ppmc_pkg::PPMC_MODE_SPP_EXT;
        `PPMC_ST_EPP17:      mode_nxt = ppmc_pkg::PPMC_MODE_EPP17;
        `PPMC_ST_EPP19:      mode_nxt = ppmc_pkg::PPMC_MODE_EPP19;
        default:             mode_nxt = ppmc_pkg::PPMC_MODE_ECP;
      endcase
    end else begin
      unique case (extended_mode_control_r[7:5])
        `PPMC_EM_SPP_COMPAT: mode_nxt = ppmc_pkg::PPMC_MODE_SPP_COMPAT;
        `PPMC_EM_SPP_EXT:    mode_nxt = ppmc_pkg::PPMC_MODE_SPP_EXT;
        `PPMC_EM_FIFO_OUT:   mode_nxt = ppmc_pkg::PPMC_MODE_FIFO_OUT;
        `PPMC_EM_EPP: begin
          mode_nxt = second_control_r[`PPMC_SC_EPP19_BIT] ? ppmc_pkg::PPMC_MODE_EPP19
                                                            : ppmc_pkg::PPMC_MODE_EPP17;
        end
        default:             mode_nxt = ppmc_pkg::PPMC_MODE_ECP;
      endcase
    end
  end

  assign fifo_mode = (mode_q_r == 3'(ppmc_pkg::PPMC_MODE_FIFO_OUT));
  assign ecp_mode  = (mode_q_r == 3'(ppmc_pkg::PPMC_MODE_ECP));
  assign mode_chg  = (mode_q_r != 3'(mode_nxt));

  // Registered mode; reset values select ECP so the port starts there.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_q_r <= 3'(ppmc_pkg::PPMC_MODE_ECP);
    end else begin
      mode_q_r <= 3'(mode_nxt);
    end
  end

  // Configuration space writes.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      port_mode_configuration_r <= `PPMC_RST_PORT_MODE;
      function_enable_first_r   <= `PPMC_RST_FUNC_EN;
      route_cfg_r               <= `PPMC_RST_ROUTE;
    end else if (CFG_WR_I) begin
      if (CFG_IDX_I == `PPMC_CFG_PORT_MODE) begin
        port_mode_configuration_r <= CFG_WDATA_I;
      end
      if (CFG_IDX_I == `PPMC_CFG_FUNC_EN) begin
        function_enable_first_r <= CFG_WDATA_I;
      end
      // Lines 0, 2 and 13 are refused; the old routing stays.
      if (CFG_IDX_I == `PPMC_CFG_ROUTE && CFG_WDATA_I[3:0] != 4'h0 &&
          CFG_WDATA_I[3:0] != `PPMC_IRQ_BAD_A && CFG_WDATA_I[3:0] != `PPMC_IRQ_BAD_B) begin
        route_cfg_r <= CFG_WDATA_I;
      end
    end
  end

  // Configuration space reads; unknown indexes read as zero.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CFG_RDATA_O <= 8'h00;
    end else if (CFG_RD_I) begin
      if (CFG_IDX_I == `PPMC_CFG_PORT_MODE) begin
        CFG_RDATA_O <= port_mode_configuration_r;
      end else if (CFG_IDX_I == `PPMC_CFG_FUNC_EN) begin
        CFG_RDATA_O <= function_enable_first_r;
      end else if (CFG_IDX_I == `PPMC_CFG_ROUTE) begin
        CFG_RDATA_O <= route_cfg_r;
      end else begin
        CFG_RDATA_O <= 8'h00;
      end
    end
  end

  // Port register writes; ignored while the port is inactive.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      extended_mode_control_r <= `PPMC_RST_EMC;
      second_level_index_r    <= 8'h00;
      second_control_r        <= `PPMC_RST_SECOND;
      dma_route_r             <= 8'h00;
      data_latch_r            <= 8'h00;
      ctrl_r                  <= 8'h00;
    end else if (PORT_WR_I && active) begin
      unique case (PORT_OFS_I)
        `PPMC_OFS_DATA:     data_latch_r <= PORT_WDATA_I;
        `PPMC_OFS_CTRL:     ctrl_r <= PORT_WDATA_I;
        `PPMC_OFS_EMC:      extended_mode_control_r <= PORT_WDATA_I;
        `PPMC_OFS_SL_INDEX: second_level_index_r <= PORT_WDATA_I;
        `PPMC_OFS_SL_DATA: begin
          if (second_level_index_r[2:0] == `PPMC_SL_SECOND_CTRL) begin
            second_control_r <= PORT_WDATA_I;
          end else if (second_level_index_r[2:0] == `PPMC_SL_ROUTE &&
                       PORT_WDATA_I[1:0] < 2'(`PPMC_DMA_CHANNELS)) begin
            dma_route_r <= PORT_WDATA_I;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Port register reads; the data port reads the pins only in extended input direction.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PORT_RDATA_O <= 8'h00;
    end else if (PORT_RD_I && active) begin
      unique case (PORT_OFS_I)
        `PPMC_OFS_DATA:     PORT_RDATA_O <= (mode_q_r == 3'(ppmc_pkg::PPMC_MODE_SPP_EXT) &&
                                             ctrl_r[`PPMC_CTRL_DIR_BIT]) ? PD_I : data_latch_r;
        `PPMC_OFS_STATUS:   PORT_RDATA_O <= {BUSY_I, ACK_N_I, 6'h3F};
        `PPMC_OFS_CTRL:     PORT_RDATA_O <= ctrl_r;
        `PPMC_OFS_EMC:      PORT_RDATA_O <= {extended_mode_control_r[7:3], fifo_thr, fifo_full, fifo_empty};
        `PPMC_OFS_SL_INDEX: PORT_RDATA_O <= second_level_index_r;
        `PPMC_OFS_SL_DATA: begin
          if (second_level_index_r[2:0] == `PPMC_SL_SECOND_CTRL) begin
            PORT_RDATA_O <= second_control_r;
          end else if (second_level_index_r[2:0] == `PPMC_SL_ROUTE) begin
            PORT_RDATA_O <= dma_route_r;
          end else begin
            PORT_RDATA_O <= 8'h00;
          end
        end
        default:            PORT_RDATA_O <= 8'h00;
      endcase
    end
  end

  // Writes to the FIFO address (extended control offset minus two) feed the FIFO in FIFO modes.
  assign fifo_wr  = active && (fifo_mode || ecp_mode) &&
                    ((PORT_WR_I && PORT_OFS_I == `PPMC_OFS_EMC - 11'h002) || dma_ack);
  assign dma_sel  = dma_route_r[1:0];
  assign dma_ack  = !ISA_DACK_N_I[dma_sel];
  assign fifo_pop = hs_take;

  ppmc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .THR   (FIFO_THR)
  ) u_fifo (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .flush_i    (mode_chg),
    .wr_valid_i (fifo_wr),
    .wr_data_i  (PORT_WDATA_I),
    .wr_ready_o (fifo_wr_ready),
    .rd_valid_o (fifo_rd_valid),
    .rd_data_o  (fifo_rd_data),
    .rd_ready_i (fifo_pop),
    .empty_o    (fifo_empty),
    .full_o     (fifo_full),
    .thr_o      (fifo_thr)
  );

  // The sequencer drains the FIFO only in hardware-handshake modes.
  ppmc_strobe #(
    .PHASE (HS_PHASE)
  ) u_strobe (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .valid_i    (fifo_rd_valid && (fifo_mode || ecp_mode) && active),
    .take_o     (hs_take),
    .busy_i     (BUSY_I),
    .strobe_n_o (hs_strobe_n),
    .active_o   (hs_active)
  );

  // Pins are driven only when active and not in extended input direction or EPP 1.7 or 1.9 reads.
  assign pd_drive = active && !((mode_q_r == 3'(ppmc_pkg::PPMC_MODE_SPP_EXT) ||
                                 mode_q_r == 3'(ppmc_pkg::PPMC_MODE_EPP17) ||
                                 mode_q_r == 3'(ppmc_pkg::PPMC_MODE_EPP19)) &&
                                ctrl_r[`PPMC_CTRL_DIR_BIT]);

  // Peripheral outputs; software controls the strobe bit outside FIFO modes.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PD_O       <= 8'h00;
      PD_OE_O    <= 1'b0;
      STROBE_N_O <= 1'b1;
    end else begin
      PD_OE_O <= pd_drive;
      if (hs_take) begin
        PD_O <= fifo_rd_data;
      end else if (!(fifo_mode || ecp_mode)) begin
        PD_O <= data_latch_r;
      end
      // EPP 1.7 strobes without waiting on busy, EPP 1.9 holds strobe off while busy.
      if (fifo_mode || ecp_mode) begin
        STROBE_N_O <= hs_strobe_n;
      end else if (mode_q_r == 3'(ppmc_pkg::PPMC_MODE_EPP19)) begin
        STROBE_N_O <= !(ctrl_r[0] && !BUSY_I);
      end else begin
        STROBE_N_O <= !(ctrl_r[0] && active);
      end
    end
  end

  // Interrupt and DMA routing; the request falls once the FIFO is full.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ISA_IRQ_O <= 16'h0000;
      ISA_DRQ_O <= 3'h0;
      MODE_O    <= 3'(ppmc_pkg::PPMC_MODE_ECP);
      ACTIVE_O  <= 1'b0;
    end else begin
      ISA_IRQ_O <= (active && ((ecp_mode && !fifo_thr) || (!ACK_N_I && ctrl_r[4])))
                   ? (16'h0001 << route_cfg_r[3:0]) : 16'h0000;
      ISA_DRQ_O <= (active && ecp_mode && fifo_wr_ready && extended_mode_control_r[3])
                   ? (3'h1 << dma_sel) : 3'h0;
      MODE_O    <= mode_q_r;
      ACTIVE_O  <= active || hs_active;
    end
  end
endmodule

// >>> testbench/ppmc_top_sva.sv
// Assertion checker of the port mode logic.
`timescale 1ns/10ps
module ppmc_top_sva #(
  parameter int HS_PHASE = 4
) (
  // Clock and reset.
  input logic        CLK_I,
  input logic        RST_N_I,
  // Register writes.
  input logic        CFG_WR_I,
  input logic [7:0]  CFG_IDX_I,
  input logic [7:0]  CFG_WDATA_I,
  input logic        PORT_WR_I,
  input logic [10:0] PORT_OFS_I,
  input logic [7:0]  PORT_WDATA_I,
  // Observed outputs.
  input logic [15:0] ISA_IRQ_O,
  input logic [2:0]  ISA_DRQ_O,
  input logic        PD_OE_O,
  input logic        STROBE_N_O,
  input logic [2:0]  MODE_O,
  input logic        ACTIVE_O
);
  logic [7:0] pm_r;
  logic [7:0] idx_r;
  logic [2:0] emc_r;
  logic       sc4_r;
  logic       ok_nxt;
  logic [2:0] exp_nxt;
  logic [7:0] exp_r;
  logic [3:0] low_r;
  logic       pw;
  assign pw = PORT_WR_I && ACTIVE_O;
  // Shadow of the mode registers.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pm_r  <= 8'hF0;
      idx_r <= 8'h00;
      emc_r <= 3'h3;
      sc4_r <= 1'b0;
    end else begin
      if (CFG_WR_I && CFG_IDX_I == 8'hF0) pm_r <= CFG_WDATA_I;
      if (pw && PORT_OFS_I == 11'h402) emc_r <= PORT_WDATA_I[7:5];
      if (pw && PORT_OFS_I == 11'h403) idx_r <= PORT_WDATA_I;
      if (pw && PORT_OFS_I == 11'h404 && idx_r == 8'h02) sc4_r <= PORT_WDATA_I[4];
    end
  end
  // Expected mode; undefined codes switch the check off.
  always_comb begin
    ok_nxt  = !pm_r[4] && !pm_r[7];
    exp_nxt = pm_r[7:5];
    if (pm_r[4] && pm_r[7:6] == 2'h3) begin
      ok_nxt  = (emc_r < 3'h5);
      exp_nxt = (emc_r == 3'h4) ? {2'h1, sc4_r} : (emc_r[1] ? emc_r + 3'h2 : emc_r);
    end
  end
  // Two stages, for the mode register and the output register behind it.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) exp_r <= 8'hDD;
    else exp_r <= {exp_r[3:0], ok_nxt, exp_nxt};
  end
  // Counts strobe-low cycles.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || STROBE_N_O) low_r <= 4'h0;
    else low_r <= low_r + 4'h1;
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  sequence en_write(logic v);
    CFG_WR_I && CFG_IDX_I == 8'h00 && CFG_WDATA_I[4] == v;
  endsequence
  sequence strobe_end;
    $rose(STROBE_N_O) && MODE_O == 3'h4;
  endsequence
  a_reset_mode: assert property ($rose(RST_N_I) |-> MODE_O == 3'h5 && !ACTIVE_O && STROBE_N_O)
    else $error("bad state after reset");
  a_mode_tracks: assert property (exp_r[7] |-> MODE_O == exp_r[6:4])
    else $error("mode off configuration");
  a_irq_lines: assert property (!ISA_IRQ_O[0] && !ISA_IRQ_O[2] && !ISA_IRQ_O[13] && $onehot0(ISA_IRQ_O))
    else $error("bad interrupt lines");
  a_dma_onehot: assert property ($onehot0(ISA_DRQ_O))
    else $error("several dma requests");
  a_enable_on: assert property (en_write(1'b1) |-> ##2 ACTIVE_O)
    else $error("port not activated");
  a_enable_off: assert property (en_write(1'b0) |-> ##2 !ACTIVE_O)
    else $error("port not deactivated");
  a_compat_drive: assert property ((ACTIVE_O && MODE_O == 3'h0) [*2] |-> PD_OE_O)
    else $error("compat data not driven");
  a_strobe_width: assert property (strobe_end |-> low_r == HS_PHASE)
    else $error("bad strobe width");
endmodule
bind ppmc_top ppmc_top_sva #(.HS_PHASE(HS_PHASE)) u_sva (.*);

// >>> testbench/ppmc_periph.sv
// Peripheral model that answers strobes with busy and acknowledge.
`timescale 1ns/10ps
module ppmc_periph (
  // Bench controls.
  input  logic       clk_i,
  input  logic       slow_i,
  input  logic [7:0] tx_i,
  // Port pins.
  input  logic       strobe_n_i,
  input  logic [7:0] pd_i,
  input  logic       pd_oe_i,
  output logic       busy_o,
  output logic       ack_n_o,
  output logic [7:0] pd_o,
  // Capture record.
  output logic [7:0] rx_o,
  output int         rx_cnt_o
);
  logic strb_q;
  int   wait_q;
  // The port's byte while it drives, else the model's own.
  assign pd_o = pd_oe_i ? pd_i : tx_i;
  // A strobe edge latches the byte; busy holds a short or long spell, then one ack.
  always @(posedge clk_i) begin
    strb_q <= strobe_n_i;
    ack_n_o <= (wait_q != 1);
    if (strb_q && !strobe_n_i) begin
      rx_o <= pd_o;
      rx_cnt_o <= rx_cnt_o + 1;
      busy_o <= 1'b1;
      wait_q <= slow_i ? 40 : 3;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
      busy_o <= (wait_q > 1);
    end
  end
  initial begin
    {busy_o, ack_n_o, strb_q, rx_o, rx_cnt_o, wait_q} = {3'h3, 8'h00, 32'd0, 32'd0};
  end
endmodule

// >>> testbench/parallel_port_mode_config_bench.sv
// Self-checking bench of the port mode logic.
`timescale 1ns/10ps
module parallel_port_mode_config_bench;
  logic clk, rst_n, cfg_wr, cfg_rd, port_wr, port_rd, pd_oe, strobe_n, busy, ack_n, active, slow;
  logic [7:0]  cfg_idx, cfg_wd, cfg_q, port_wd, port_q, pd_in, pd_out, tx, rx, scr, d;
  logic [10:0] ofs;
  logic [15:0] irq;
  logic [2:0]  drq, mode, em;
  logic [3:0]  cur;
  logic [1:0]  dc;
  logic [7:0]  fb [5];
  int          failures, compares, rx_cnt, base;
  ppmc_top dut (.CLK_I(clk), .RST_N_I(rst_n), .CFG_WR_I(cfg_wr), .CFG_RD_I(cfg_rd), .CFG_IDX_I(cfg_idx),
    .CFG_WDATA_I(cfg_wd), .CFG_RDATA_O(cfg_q), .PORT_WR_I(port_wr), .PORT_RD_I(port_rd), .PORT_OFS_I(ofs),
    .PORT_WDATA_I(port_wd), .PORT_RDATA_O(port_q), .ISA_IRQ_O(irq), .ISA_DRQ_O(drq), .ISA_DACK_N_I(3'h7),
    .PD_I(pd_in), .PD_O(pd_out), .PD_OE_O(pd_oe), .STROBE_N_O(strobe_n), .BUSY_I(busy), .ACK_N_I(ack_n),
    .MODE_O(mode), .ACTIVE_O(active));
  ppmc_periph u_periph (.clk_i(clk), .slow_i(slow), .tx_i(tx), .strobe_n_i(strobe_n), .pd_i(pd_out),
    .pd_oe_i(pd_oe), .busy_o(busy), .ack_n_o(ack_n), .pd_o(pd_in), .rx_o(rx), .rx_cnt_o(rx_cnt));
  function logic [2:0] dyn_mode(input logic [2:0] e, input logic s4);
    return (e == 3'h4) ? {2'h1, s4} : (e[1] ? e + 3'h2 : e);
  endfunction
  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // One access; the strobe spans one rising edge, read data lands in scr.
  task acc(input bit pt, input bit rd, input logic [10:0] a, input logic [7:0] v);
    @(negedge clk);
    {cfg_wr, cfg_rd, port_wr, port_rd} = {!pt && !rd, !pt && rd, pt && !rd, pt && rd};
    {cfg_idx, ofs, cfg_wd, port_wd} = {a[7:0], a, v, v};
    @(negedge clk);
    {cfg_wr, cfg_rd, port_wr, port_rd} = 4'h0;
    @(negedge clk);
    scr = pt ? port_q : cfg_q;
  endtask
  task chk_mode(input logic [2:0] e);
    repeat (2) @(negedge clk);
    chk("mode", 16'(e), 16'(mode));
  endtask
  task wait_rx(input int n);
    int k;
    for (k = 0; k < 600 && rx_cnt < n; k++) @(negedge clk);
    if (k == 600) begin
      failures++;
      $display("CHECK FAILED rx count expected %0d seen %0d", n, rx_cnt);
      wrap_up();
    end
  endtask
  task do_reset;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hang counts as a mismatch.
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    {cfg_wr, cfg_rd, port_wr, port_rd, cfg_idx, ofs, cfg_wd, port_wd, slow, tx} = 0;
    {failures, compares} = 0;
    void'($urandom(32'h9F2B8272));
    do_reset();
    chk("reset mode", 16'h5, 16'(mode));
    acc(1'b0, 1'b1, 11'h0F0, 8'h00);
    chk("port mode cfg", 16'hF0, 16'(scr));
    acc(1'b1, 1'b0, 11'h402, 8'h00);
    chk_mode(3'h5);
    acc(1'b0, 1'b0, 11'h000, 8'h10);
    chk("active", 16'h1, 16'(active));
    acc(1'b1, 1'b1, 11'h402, 8'h00);
    chk("emc field", 16'h3, 16'(scr[7:5]));
    $display("test reset_enable done");
    // Sub-modes, both EPP revisions, then a random tail.
    for (int i = 0; i < 16; i++) begin
      em = (i < 10) ? 3'(i / 2) : 3'($urandom_range(4));
      d = 8'($urandom);
      if (i < 10) d[4] = i[0];
      acc(1'b1, 1'b0, 11'h403, 8'h02);
      acc(1'b1, 1'b0, 11'h404, d);
      acc(1'b1, 1'b1, 11'h404, 8'h00);
      chk("second control", {d[7], d[4]}, {scr[7], scr[4]});
      acc(1'b1, 1'b0, 11'h402, {em, 5'h00});
      chk_mode(dyn_mode(em, d[4]));
    end
    $display("test dynamic_modes done");
    acc(1'b1, 1'b0, 11'h402, 8'h00);
    d = 8'($urandom);
    acc(1'b1, 1'b0, 11'h000, d);
    chk("compat pins", {8'h01, d}, {7'h00, pd_oe, pd_out});
    acc(1'b1, 1'b1, 11'h000, 8'h00);
    chk("compat latch", 16'(d), 16'(scr));
    acc(1'b1, 1'b0, 11'h402, 8'h20);
    acc(1'b1, 1'b0, 11'h002, 8'h20);
    tx = 8'($urandom);
    acc(1'b1, 1'b1, 11'h000, 8'h00);
    chk("ext input", {8'h00, tx}, {7'h00, pd_oe, scr});
    acc(1'b1, 1'b0, 11'h002, 8'h00);
    acc(1'b1, 1'b0, 11'h000, ~tx);
    chk("ext output", {8'h01, ~tx}, {7'h00, pd_oe, pd_out});
    $display("test spp_data done");
    acc(1'b1, 1'b0, 11'h402, 8'h40);
    base = rx_cnt;
    slow = 1'b1;
    for (int j = 0; j < 5; j++) begin
      fb[j] = 8'($urandom);
      acc(1'b1, 1'b0, 11'h400, fb[j]);
    end
    acc(1'b1, 1'b1, 11'h402, 8'h00);
    chk("fifo not empty", 16'h0, 16'(scr[0]));
    for (int j = 0; j < 5; j++) begin
      wait_rx(base + j + 1);
      chk("byte out", 16'(fb[j]), 16'(rx));
      slow = j[0];
    end
    repeat (30) @(negedge clk);
    acc(1'b1, 1'b1, 11'h402, 8'h00);
    chk("fifo empty", 16'h1, 16'(scr[0]));
    $display("test fifo_out done");
    acc(1'b1, 1'b0, 11'h402, 8'h68);
    cur = 4'h7;
    for (int n = 0; n < 16; n++) begin
      acc(1'b0, 1'b0, 11'h0F1, {4'h0, n[3:0]});
      if (n != 0 && n != 2 && n != 13) cur = n[3:0];
      repeat (2) @(negedge clk);
      chk("irq route", 16'h1 << cur, irq);
    end
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 1'b0, 11'h403, 8'h04);
      acc(1'b1, 1'b0, 11'h404, {6'h00, c[1:0]});
      if (c < 3) dc = c[1:0];
      repeat (2) @(negedge clk);
      chk("drq route", 16'(3'h1 << dc), 16'(drq));
    end
    $display("test routing done");
    for (int s = 0; s < 4; s++) begin
      acc(1'b0, 1'b0, 11'h0F0, {s[2:0], 5'h00});
      chk_mode(s[2:0]);
      acc(1'b1, 1'b0, 11'h402, 8'h60);
      chk_mode(s[2:0]);
    end
    acc(1'b0, 1'b0, 11'h0F0, 8'hD0);
    chk_mode(3'h5);
    acc(1'b0, 1'b0, 11'h000, 8'h00);
    chk("inactive", 16'h0, 16'(active));
    do_reset();
    chk("rereset", 16'hA, {mode, active});
    $display("test static_and_reset done");
    wrap_up();
  end
endmodule
